// ### tone_pkg.sv
// constants and types shared by the key-click tone generator
package tone_pkg;

  // ***********************************************
  // register map, page 0
  // ***********************************************
  localparam logic [7:0] TONE_PAGE = 8'h00;
  localparam logic [7:0] OFF_LEFT_CTRL = 8'h47;
  localparam logic [7:0] OFF_RIGHT_CTRL = 8'h48;
  localparam logic [7:0] OFF_LEN_HIGH = 8'h49;
  localparam logic [7:0] OFF_LEN_MID = 8'h4A;
  localparam logic [7:0] OFF_LEN_LOW = 8'h4B;
  localparam logic [7:0] OFF_SIN_HIGH = 8'h4C;
  localparam logic [7:0] OFF_SIN_LOW = 8'h4D;
  localparam logic [7:0] OFF_COS_HIGH = 8'h4E;
  localparam logic [7:0] OFF_COS_LOW = 8'h4F;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int START_BIT = 7;
  localparam int MASTER_LSB = 6;
  localparam int VOL_W = 6;
  localparam int MASTER_W = 2;

  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [7:0] LEN_HIGH_RST = 8'h00;
  localparam logic [7:0] LEN_MID_RST = 8'h00;
  localparam logic [7:0] LEN_LOW_RST = 8'hEE;
  localparam logic [7:0] SIN_HIGH_RST = 8'h10;
  localparam logic [7:0] SIN_LOW_RST = 8'hD8;
  localparam logic [7:0] COS_HIGH_RST = 8'h7E;
  localparam logic [7:0] COS_LOW_RST = 8'hE3;
  localparam logic [5:0] VOL_RST = 6'h00;
  localparam logic [1:0] MASTER_RST = 2'h0;

  // ***********************************************
  // gain mantissas, Q14, for +2 dB down to -3 dB
  // ***********************************************
  localparam logic [14:0] GAIN_M0 = 15'h5092;
  localparam logic [14:0] GAIN_M1 = 15'h47CF;
  localparam logic [14:0] GAIN_M2 = 15'h4000;
  localparam logic [14:0] GAIN_M3 = 15'h390A;
  localparam logic [14:0] GAIN_M4 = 15'h32D6;
  localparam logic [14:0] GAIN_M5 = 15'h2D4F;
  localparam int GAIN_FRAC = 14;
  localparam int DB_PER_OCTAVE = 6;

  // ***********************************************
  // stream and buffering
  // ***********************************************
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } sample_t;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } reg_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN = 2'b11
  } tone_state_t;

endpackage

// ### tone_sample_fifo.sv
// synchronous valid/ready fifo for playback samples
`timescale 1ns/100ps
module tone_sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic ready_r;
  logic valid_r;
  wire push = i_valid & ready_r;
  wire pop = valid_r & i_ready;

  // flags are registered so both handshake outputs leave flops
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  assign o_ready = ready_r;
  assign o_valid = valid_r;
  assign o_data = mem[rd_ptr_r];

  always_ff @(posedge i_clk)
  begin
    if (i_ce && push)
    begin
      mem[wr_ptr_r] <= i_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else if (i_ce)
    begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != CW'(DEPTH));
      valid_r <= (cnt_nxt != '0);
    end
  end
endmodule

// ### tone_capable_playback_block.sv
// key-click sine-burst generator mixed into the playback stream
`timescale 1ns/100ps
module tone_capable_playback_block (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire tone_pkg::reg_req_t i_reg,
  output logic [7:0] o_reg_rdata,
  input wire logic i_in_valid,
  input wire tone_pkg::sample_t i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output tone_pkg::sample_t o_out_data,
  input wire logic i_out_ready,
  output logic o_tone_active
);

  // ***********************************************
  // register storage
  // ***********************************************
  logic [5:0] left_vol_r;
  logic [7:0] right_ctrl_r;
  logic [7:0] len_high_r;
  logic [7:0] len_mid_r;
  logic [7:0] len_low_r;
  logic [7:0] sin_high_r;
  logic [7:0] sin_low_r;
  logic [7:0] cos_high_r;
  logic [7:0] cos_low_r;
  logic [7:0] rdata_r;

  // ***********************************************
  // burst and oscillator state
  // ***********************************************
  tone_pkg::tone_state_t state_r;
  tone_pkg::tone_state_t state_nxt;
  logic [23:0] remain_r;
  logic signed [15:0] osc_cur_r;
  logic signed [15:0] osc_prev_r;
  logic out_valid_r;
  tone_pkg::sample_t out_data_r;
  logic busy_r;

  // ***********************************************
  // register decode
  // ***********************************************
  wire page_hit = (i_reg.page == tone_pkg::TONE_PAGE);
  wire wr = i_reg.we & page_hit;
  wire rd = i_reg.re & page_hit;
  // one address compare per register, shared by write and read
  wire hit_left = (i_reg.addr == tone_pkg::OFF_LEFT_CTRL);
  wire hit_right = (i_reg.addr == tone_pkg::OFF_RIGHT_CTRL);
  wire hit_len_h = (i_reg.addr == tone_pkg::OFF_LEN_HIGH);
  wire hit_len_m = (i_reg.addr == tone_pkg::OFF_LEN_MID);
  wire hit_len_l = (i_reg.addr == tone_pkg::OFF_LEN_LOW);
  wire hit_sin_h = (i_reg.addr == tone_pkg::OFF_SIN_HIGH);
  wire hit_sin_l = (i_reg.addr == tone_pkg::OFF_SIN_LOW);
  wire hit_cos_h = (i_reg.addr == tone_pkg::OFF_COS_HIGH);
  wire hit_cos_l = (i_reg.addr == tone_pkg::OFF_COS_LOW);
  wire wr_left = wr & hit_left;
  wire wr_right = wr & hit_right;
  wire wr_len_h = wr & hit_len_h;
  wire wr_len_m = wr & hit_len_m;
  wire wr_len_l = wr & hit_len_l;
  wire wr_sin_h = wr & hit_sin_h;
  wire wr_sin_l = wr & hit_sin_l;
  wire wr_cos_h = wr & hit_cos_h;
  wire wr_cos_l = wr & hit_cos_l;
  wire start_req = wr_left & i_reg.wdata[tone_pkg::START_BIT];

  // start bit reads back the burst state, so it drops by itself
  wire busy = (state_r != tone_pkg::ST_IDLE);

  wire [7:0] left_rd = {busy, 1'b0, left_vol_r};
  wire [7:0] rdata_nxt =
    hit_left ? left_rd :
    hit_right ? right_ctrl_r :
    hit_len_h ? len_high_r :
    hit_len_m ? len_mid_r :
    hit_len_l ? len_low_r :
    hit_sin_h ? sin_high_r :
    hit_sin_l ? sin_low_r :
    hit_cos_h ? cos_high_r :
    hit_cos_l ? cos_low_r : 8'h00;

  // ***********************************************
  // assembled fields
  // ***********************************************
  wire [23:0] burst_len = {len_high_r, len_mid_r, len_low_r};
  wire signed [15:0] sin_coef = {sin_high_r, sin_low_r};
  wire signed [15:0] cos_coef = {cos_high_r, cos_low_r};
  wire [5:0] right_vol = right_ctrl_r[5:0];
  wire [1:0] master_vol =
    right_ctrl_r[tone_pkg::MASTER_LSB +: tone_pkg::MASTER_W];

  // ***********************************************
  // input buffer
  // ***********************************************
  logic fifo_valid;
  tone_pkg::sample_t fifo_data;
  logic fifo_ready_in;
  wire take = fifo_valid & (~out_valid_r | i_out_ready);

  tone_sample_fifo #(
    .WIDTH($bits(tone_pkg::sample_t)),
    .DEPTH(tone_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_valid(i_in_valid),
    .i_data(i_in_data),
    .o_ready(fifo_ready_in),
    .o_valid(fifo_valid),
    .o_data(fifo_data),
    .i_ready(take)
  );

  // ***********************************************
  // oscillator: y[n+1] = 2c*y[n] - y[n-1], Q15
  // ***********************************************
  wire signed [33:0] osc_prod = 34'(cos_coef * osc_cur_r);
  wire signed [33:0] osc_twice = osc_prod >>> 14;
  wire signed [33:0] osc_sum = osc_twice - 34'(osc_prev_r);
  // saturation keeps a rounding drift near full scale from wrapping
  wire signed [15:0] osc_next =
    (osc_sum > 34'sd32767) ? 16'sh7FFF :
    (osc_sum < -34'sd32768) ? 16'sh8000 : osc_sum[15:0];

  // silent outside the run state, so playback passes untouched
  wire signed [15:0] tone_val =
    (state_r == tone_pkg::ST_RUN) ? osc_cur_r : 16'sh0000;

  // ***********************************************
  // volume: mantissa per dB within a 6 dB octave, then shift
  // ***********************************************
  function automatic logic [14:0] gain_mant(input logic [5:0] step);
    logic [5:0] idx;
    idx = step % 6'(tone_pkg::DB_PER_OCTAVE);
    case (idx)
      6'h00: gain_mant = tone_pkg::GAIN_M0;
      6'h01: gain_mant = tone_pkg::GAIN_M1;
      6'h02: gain_mant = tone_pkg::GAIN_M2;
      6'h03: gain_mant = tone_pkg::GAIN_M3;
      6'h04: gain_mant = tone_pkg::GAIN_M4;
      default: gain_mant = tone_pkg::GAIN_M5;
    endcase
  endfunction

  function automatic logic signed [17:0] scale_tone(
    input logic signed [15:0] tone,
    input logic [5:0] vol,
    input logic [1:0] master
  );
    logic signed [31:0] prod;
    logic [5:0] sh;
    prod = 32'(tone * $signed({1'b0, gain_mant(vol)}));
    sh = 6'(tone_pkg::GAIN_FRAC) + vol / 6'(tone_pkg::DB_PER_OCTAVE)
      + 6'(master);
    prod = prod >>> sh;
    scale_tone = prod[17:0];
  endfunction

  function automatic logic signed [15:0] sat_add(
    input logic signed [15:0] play,
    input logic signed [17:0] tone
  );
    logic signed [18:0] sum;
    sum = 19'(play) + 19'(tone);
    if (sum > 19'sd32767)
      sat_add = 16'sh7FFF;
    else if (sum < -19'sd32768)
      sat_add = 16'sh8000;
    else
      sat_add = sum[15:0];
  endfunction

  wire signed [17:0] tone_left = scale_tone(tone_val, left_vol_r,
    master_vol);
  wire signed [17:0] tone_right = scale_tone(tone_val, right_vol,
    master_vol);

  // playback arrives already past the dac volume stage
  tone_pkg::sample_t mixed;
  assign mixed.left = sat_add(fifo_data.left, tone_left);
  assign mixed.right = sat_add(fifo_data.right, tone_right);

  // ***********************************************
  // burst sequencing
  // ***********************************************
  wire first_take = take & (state_r == tone_pkg::ST_ARMED);
  wire run_take = take & (state_r == tone_pkg::ST_RUN);
  wire last_run = run_take & (remain_r == 24'h000001);
  wire len_zero = (burst_len == 24'h000000);
  wire len_one = (burst_len == 24'h000001);

  // a start that lands on the ending sample in ST_RUN wins and re-arms
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      tone_pkg::ST_IDLE:
        if (start_req)
          state_nxt = tone_pkg::ST_ARMED;
      tone_pkg::ST_ARMED:
        if (len_zero)
          state_nxt = tone_pkg::ST_IDLE;
        else if (first_take)
          state_nxt = len_one ? tone_pkg::ST_IDLE : tone_pkg::ST_RUN;
      tone_pkg::ST_RUN:
        if (last_run)
          state_nxt = start_req ? tone_pkg::ST_ARMED
            : tone_pkg::ST_IDLE;
      default:
        state_nxt = tone_pkg::ST_IDLE;
    endcase
  end

  // ***********************************************
  // register writes
  // ***********************************************
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      left_vol_r <= tone_pkg::VOL_RST;
      right_ctrl_r <= {tone_pkg::MASTER_RST, tone_pkg::VOL_RST};
      len_high_r <= tone_pkg::LEN_HIGH_RST;
      len_mid_r <= tone_pkg::LEN_MID_RST;
      len_low_r <= tone_pkg::LEN_LOW_RST;
      sin_high_r <= tone_pkg::SIN_HIGH_RST;
      sin_low_r <= tone_pkg::SIN_LOW_RST;
      cos_high_r <= tone_pkg::COS_HIGH_RST;
      cos_low_r <= tone_pkg::COS_LOW_RST;
      rdata_r <= 8'h00;
    end
    else if (i_ce)
    begin
      if (wr_left)
        left_vol_r <= i_reg.wdata[5:0];
      if (wr_right)
        right_ctrl_r <= i_reg.wdata;
      if (wr_len_h)
        len_high_r <= i_reg.wdata;
      if (wr_len_m)
        len_mid_r <= i_reg.wdata;
      if (wr_len_l)
        len_low_r <= i_reg.wdata;
      if (wr_sin_h)
        sin_high_r <= i_reg.wdata;
      if (wr_sin_l)
        sin_low_r <= i_reg.wdata;
      if (wr_cos_h)
        cos_high_r <= i_reg.wdata;
      if (wr_cos_l)
        cos_low_r <= i_reg.wdata;
      if (rd)
        rdata_r <= rdata_nxt;
    end
  end

  // ***********************************************
  // oscillator and sample counter
  // ***********************************************
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_r <= tone_pkg::ST_IDLE;
      busy_r <= 1'b0;
      remain_r <= 24'h000000;
      osc_cur_r <= 16'sh0000;
      osc_prev_r <= 16'sh0000;
    end
    else if (i_ce)
    begin
      state_r <= state_nxt;
      // status pin leaves a flop yet tracks the start bit readback
      busy_r <= (state_nxt != tone_pkg::ST_IDLE);
      if (first_take)
      begin
        // y0 = 0 went out with this sample, y1 = sine comes next
        osc_cur_r <= sin_coef;
        osc_prev_r <= 16'sh0000;
        remain_r <= burst_len - 24'h000001;
      end
      else if (run_take)
      begin
        osc_cur_r <= osc_next;
        osc_prev_r <= osc_cur_r;
        remain_r <= remain_r - 24'h000001;
      end
    end
  end

  // ***********************************************
  // output stage toward the dac
  // ***********************************************
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end
    else if (i_ce)
    begin
      if (take)
      begin
        out_valid_r <= 1'b1;
        out_data_r <= mixed;
      end
      else if (i_out_ready)
        out_valid_r <= 1'b0;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_in_ready = fifo_ready_in;
  assign o_out_valid = out_valid_r;
  assign o_out_data = out_data_r;
  assign o_tone_active = busy_r;

endmodule

// ### tone_block_props.sv
// assertion checker for the tone playback block
`timescale 1ns/100ps
module tone_block_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire tone_pkg::reg_req_t i_reg,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_in_ready,
  input wire logic o_out_valid,
  input wire tone_pkg::sample_t o_out_data,
  input wire logic i_out_ready,
  input wire logic o_tone_active
);
  // ****************************************
  // request decode
  // ****************************************
  wire logic [7:0] adr = i_reg.addr;
  wire logic [7:0] wdat = i_reg.wdata;
  wire logic on_page = i_ce && (i_reg.page == tone_pkg::TONE_PAGE);
  wire logic rd0 = on_page && i_reg.re;
  wire logic wr0 = on_page && i_reg.we;
  wire logic at_left = (adr == tone_pkg::OFF_LEFT_CTRL);
  wire logic at_rw = (adr > tone_pkg::OFF_LEFT_CTRL) &&
    (adr <= tone_pkg::OFF_COS_LOW);
  wire logic unmapped = (adr < tone_pkg::OFF_LEFT_CTRL) ||
    (adr > tone_pkg::OFF_COS_LOW);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // ****************************************
  // properties
  // ****************************************
  AST_UNMAPPED_ZERO: assert property (
    rd0 && unmapped |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_START_ARMS: assert property (
    wr0 && at_left && wdat[7] |=> o_tone_active)
    else $error("start write did not arm");
  AST_START_READBACK: assert property (rd0 && at_left |=>
    o_reg_rdata[7] == $past(o_tone_active) && !o_reg_rdata[6])
    else $error("start bit readback wrong");
  AST_VOL_READBACK: assert property (
    wr0 && at_left ##1 rd0 && at_left |=>
    o_reg_rdata[5:0] == $past(wdat[5:0], 2))
    else $error("volume readback wrong");
  AST_RW_READBACK: assert property (
    wr0 && at_rw ##1 rd0 && adr == $past(adr) |=>
    o_reg_rdata == $past(wdat, 2))
    else $error("register readback wrong");
  AST_OUT_HOLD: assert property (o_out_valid && !i_out_ready |=>
    o_out_valid && $stable(o_out_data))
    else $error("output dropped before accept");
  AST_READY_AFTER_RESET: assert property (
    $fell(i_rst) && i_ce |=> o_in_ready)
    else $error("input not ready after reset");
  AST_CE_FREEZE: assert property (!i_ce |=> $stable(o_in_ready) &&
    $stable(o_tone_active) && $stable(o_out_valid))
    else $error("state moved with enable low");
endmodule

// ### tone_sink_model.sv
// downstream mixer stand-in that records mixed samples
`timescale 1ns/100ps
module tone_sink_model (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire tone_pkg::sample_t i_data,
  output logic o_ready
);
  tone_pkg::sample_t got[$];
  // stall is a level so backpressure can last many samples
  assign o_ready = !i_stall;
  // samples arrive already past dac volume, taken only on handshake
  always @(posedge i_clk)
    // a handshake only counts on an enabled edge, as in the block
    if (i_ce && i_valid && o_ready)
      got.push_back(i_data);
endmodule

// ### tone_capable_playback_block_bench.sv
// self-checking bench for the tone playback block
`timescale 1ns/100ps
module tone_capable_playback_block_bench;
  logic clk, rst, ce, in_valid, in_ready, out_valid, out_ready, active;
  logic stall;
  tone_pkg::reg_req_t rq;
  tone_pkg::sample_t in_data, out_data;
  logic [7:0] rdata;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;

  tone_capable_playback_block dut (.i_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_reg(rq), .o_reg_rdata(rdata), .i_in_valid(in_valid),
    .i_in_data(in_data), .o_in_ready(in_ready), .o_out_valid(out_valid),
    .o_out_data(out_data), .i_out_ready(out_ready), .o_tone_active(active));
  tone_sink_model sink (.i_clk(clk), .i_ce(ce), .i_stall(stall),
    .i_valid(out_valid), .i_data(out_data), .o_ready(out_ready));

  // ****************************************
  // common tasks
  // ****************************************
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held over exactly one rising edge
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    rq = '{page: tone_pkg::TONE_PAGE, addr: a, wdata: d, we: w, re: !w};
    @(posedge clk);
    #1;
  endtask

  task idle;
    @(negedge clk);
    rq = '0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("reg", {24'h0, e}, {24'h0, rdata});
  endtask

  // pushes {k,k}; full_stop ends at the first refusal
  task push(input int cnt, input logic full_stop, output int k);
    k = 0;
    while (k < cnt)
    begin
      @(negedge clk);
      if (in_ready === 1'b1)
      begin
        in_valid = 1'b1;
        in_data = {16'(k), 16'(k)};
        k++;
      end
      else
      begin
        in_valid = 1'b0;
        if (full_stop)
          break;
      end
    end
    @(negedge clk);
    in_valid = 1'b0;
  endtask

  task drain(input int cnt);
    int k;
    k = 0;
    while (sink.got.size() < cnt && k < 200)
    begin
      @(negedge clk);
      k++;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset_vals;
    rd(8'h47, 8'h00);
    rd(8'h48, 8'h00);
    rd(8'h49, 8'h00);
    rd(8'h4A, 8'h00);
    rd(8'h4B, 8'hEE);
    rd(8'h4C, 8'h10);
    rd(8'h4D, 8'hD8);
    rd(8'h4E, 8'h7E);
    rd(8'h4F, 8'hE3);
    rd(8'h46, 8'h00);
    rd(8'h50, 8'h00);
    idle;
  endtask

  task t_reg_rw;
    logic [7:0] a;
    for (int i = 0; i < 8; i++)
    begin
      a = 8'h48 + 8'(i);
      acc(1'b1, a, a ^ 8'hA5);
      rd(a, a ^ 8'hA5);
    end
    // bit 6 has no storage, bit 7 left clear to avoid a burst
    acc(1'b1, 8'h47, 8'h6A);
    rd(8'h47, 8'h2A);
    idle;
  endtask

  task t_fill_drain;
    @(negedge clk);
    stall = 1'b1;
    push(20, 1'b1, n);
    chk("fill", 32'h1, {31'h0, n >= tone_pkg::FIFO_DEPTH});
    chk("in_ready", 32'h0, {31'h0, in_ready});
    stall = 1'b0;
    repeat (3) @(negedge clk);
    ce = 1'b0;
    repeat (4) @(negedge clk);
    ce = 1'b1;
    drain(n);
    for (int i = 0; i < n; i++)
      chk("pass", {16'(i), 16'(i)}, sink.got[i]);
  endtask

  task t_burst;
    sink.got.delete();
    acc(1'b1, 8'h48, 8'h06);
    acc(1'b1, 8'h49, 8'h00);
    acc(1'b1, 8'h4A, 8'h00);
    acc(1'b1, 8'h4B, 8'h03);
    acc(1'b1, 8'h4C, 8'h01);
    acc(1'b1, 8'h4D, 8'h00);
    acc(1'b1, 8'h4E, 8'h7E);
    acc(1'b1, 8'h4F, 8'hE3);
    acc(1'b1, 8'h47, 8'h80);
    idle;
    chk("active", 32'h1, {31'h0, active});
    push(4, 1'b0, n);
    drain(4);
    chk("tone0", 32'h0, sink.got[0]);
    chk("tone1", 32'h014300A2, sink.got[1]);
    chk("after", 32'h00030003, sink.got[3]);
    chk("active", 32'h0, {31'h0, active});
    rd(8'h47, 8'h00);
    // second burst: master step, shorter length, oscillator restart
    acc(1'b1, 8'h48, 8'h46);
    acc(1'b1, 8'h4B, 8'h02);
    acc(1'b1, 8'h47, 8'h80);
    rd(8'h47, 8'h80);
    idle;
    push(2, 1'b0, n);
    drain(6);
    chk("tone0b", 32'h0, sink.got[4]);
    chk("master", 32'h00A20051, sink.got[5]);
    chk("active", 32'h0, {31'h0, active});
  endtask

  task t_mid_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset_vals;
  endtask

  // ****************************************
  // clock, timeout and main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      wrap_up;
    end
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    rq = '0;
    in_valid = 1'b0;
    in_data = '0;
    stall = 1'b0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset_vals;
    t_reg_rw;
    t_fill_drain;
    t_burst;
    t_mid_reset;
    wrap_up;
  end
endmodule

bind tone_capable_playback_block tone_block_props chk_i (.i_clk(i_clk),
  .i_rst(i_rst), .i_ce(i_ce), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
  .o_in_ready(o_in_ready), .o_out_valid(o_out_valid),
  .o_out_data(o_out_data), .i_out_ready(i_out_ready),
  .o_tone_active(o_tone_active));
